// File: inc/counter_array_pkg.sv
// Purpose: Shared constants, register map and helpers of the counter array block
// Assumes: 32-bit APB data, one aligned word per register, 8-bit byte addresses
// Notes: Bit positions are indices into the low byte of each register word
package counter_array_pkg;

  // Sizes
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int SUB_W = 4;
  localparam int NUM_MOD = 6;
  localparam int WD_MOD = 5;
  localparam logic [2:0] WD_IDX = 3'h5;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PULSE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_LO = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT_HI = 8'h10;
  localparam logic [SUB_W-1:0] MOD_ROW_BASE = 4'h4;
  localparam logic [SUB_W-1:0] MOD_ROW_END = 4'hA;
  localparam logic [SUB_W-1:0] MOD_MODE = 4'h0;
  localparam logic [SUB_W-1:0] MOD_CMP_LO = 4'h4;
  localparam logic [SUB_W-1:0] MOD_CMP_HI = 4'h8;

  // Field positions
  localparam int CTRL_CF = 7;
  localparam int CTRL_CR = 6;
  localparam int MD_IDLE = 7;
  localparam int MD_WATCHDOG_ENABLE_BIT = 6;
  localparam int MD_LOCK = 5;
  localparam int MD_CPS_LO = 1;
  localparam int CPS_W = 3;
  localparam int PC_RELOAD_ACCESS_SELECT = 7;
  localparam int PC_CYCLE_OVERFLOW_FLAG = 5;
  localparam int CLS_LSB = 0;
  localparam int CLS_W = 2;
  localparam int MM_WIDE = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_MAT = 3;
  localparam int MM_PWM = 1;

  // Values
  localparam logic [CLS_W-1:0] CLS_8BIT = 2'h0;
  localparam logic [CLS_W-1:0] CLS_9BIT = 2'h1;
  localparam logic [CLS_W-1:0] CLS_10BIT = 2'h2;
  localparam logic [CLS_W-1:0] CLS_11BIT = 2'h3;
  localparam logic [15:0] MASK_8 = 16'h00FF;
  localparam logic [15:0] MASK_9 = 16'h01FF;
  localparam logic [15:0] MASK_10 = 16'h03FF;
  localparam logic [15:0] MASK_11 = 16'h07FF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic WD_EN_RESET = 1'b1;

  // Low bits of the counter that make up one PWM cycle
  function automatic logic [15:0] cycle_mask(input logic [CLS_W-1:0] cls);
    unique case (cls)
      CLS_8BIT: return MASK_8;
      CLS_9BIT: return MASK_9;
      CLS_10BIT: return MASK_10;
      CLS_11BIT: return MASK_11;
    endcase
  endfunction

  function automatic logic [7:0] hi_byte(input logic [15:0] v);
    return v[HI_LSB +: BYTE_W];
  endfunction

  function automatic logic [7:0] lo_byte(input logic [15:0] v);
    return v[LO_LSB +: BYTE_W];
  endfunction

endpackage

// File: test/counter_array_pwm_watchdog_tb.sv
// Purpose: Self-checking bench for the counter array PWM and watchdog block
// Assumes: count_tick high every cycle, so one count per pclk
// Notes: Read results and pin measurements are checked from queues
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (b)); end end
module counter_array_pwm_watchdog_tb;
  import counter_array_pkg::*;
  typedef struct packed {logic [32:0] mask; logic [32:0] exp;} rd_s;
  typedef struct packed {logic [15:0] hi; logic [15:0] per;} mon_s;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdq, c0;
  logic pready, pslverr, count_tick = 1'b1, cpu_idle = 1'b0, watchdog_reset, arm = 1'b0;
  logic [5:0] module_output_pin;
  logic [2:0] sel = 3'h0;
  logic mon_valid, acc;
  logic [15:0] mon_hi, mon_per;
  rd_s rq[$];
  mon_s mq[$];
  rd_s r;
  mon_s m;
  int err_count = 0, checked = 0, cyc = 0, rst_n = 0, rst_t = 0, n0, t0, k;
  counter_array_pwm_watchdog uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick(count_tick), .cpu_idle(cpu_idle),
    .module_output_pin(module_output_pin), .watchdog_reset(watchdog_reset));
  pwm_pin_monitor mon (.pclk(pclk), .presetn(presetn), .pins(module_output_pin), .sel(sel),
    .arm(arm), .valid(mon_valid), .high_len(mon_hi), .period(mon_per));
  initial begin
    forever #20 pclk = ~pclk;
  end
  function automatic logic [7:0] ma(input logic [3:0] n, input logic [3:0] s);
    return {MOD_ROW_BASE + n, s};
  endfunction
  task automatic results();
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] mk, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back({mk, e});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_pwm(input logic [1:0] cls, input logic [15:0] v);
    logic [15:0] per;
    per = 16'h0100 << cls;
    arm <= 1'b0;
    apb(1'b1, OFS_PULSE, {24'h0, cls != CLS_8BIT, 5'h0, cls}, '0, '0);
    apb(1'b1, ma(4'h0, MOD_MODE), 32'h4A, '0, '0);
    apb(1'b1, ma(4'h0, MOD_CMP_LO), {24'h0, v[7:0]}, '0, '0);
    apb(1'b1, ma(4'h0, MOD_CMP_HI), {24'h0, cls == CLS_8BIT ? v[7:0] : v[15:8]}, '0, '0);
    apb(1'b0, ma(4'h0, MOD_CMP_LO), '0, 33'hFF, {25'h0, v[7:0]});
    @(negedge module_output_pin[0]);
    @(posedge pclk);
    arm <= 1'b1;
    mq.push_back({per - v, 16'h0000});
    mq.push_back({per - v, per});
    while (mq.size() > 0) @(posedge pclk);
    apb(1'b0, OFS_PULSE, '0, 33'h20, 33'h20);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (watchdog_reset === 1'b1) begin
      rst_n <= rst_n + 1;
      rst_t <= cyc;
    end
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      r = rq.pop_front();
      if (r.mask != 0) `CHK({pslverr, prdata} & r.mask, r.exp)
    end
    if (mon_valid && mq.size() > 0) begin
      m = mq.pop_front();
      `CHK(mon_hi, m.hi)
      if (m.per != 0) `CHK(mon_per, m.per)
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    results();
  end
  initial begin
    void'($urandom(32'h51EF2B09));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_MODE, '0, 33'h1000000FF, 33'h040);
    apb(1'b0, 8'h14, '0, 33'h1FFFFFFFF, 33'h100000000);
    apb(1'b1, OFS_MODE, '0, '0, '0);
    apb(1'b1, OFS_CTRL, 32'h40, '0, '0);
    apb(1'b1, ma(4'h2, MOD_MODE), 32'h4A, '0, '0);
    apb(1'b1, ma(4'h2, MOD_CMP_LO), 32'h10, '0, '0);
    apb(1'b0, ma(4'h2, MOD_MODE), '0, 33'hFF, 33'h0A);
    apb(1'b1, ma(4'h2, MOD_CMP_HI), 32'h20, '0, '0);
    apb(1'b0, ma(4'h2, MOD_MODE), '0, 33'hFF, 33'h4A);
    run_pwm(CLS_8BIT, 16'($urandom_range(254, 1)));
    apb(1'b1, ma(4'h0, MOD_CMP_LO), 32'h40, '0, '0);
    acc = 1'b0;
    repeat (300) begin
      @(negedge pclk);
      acc |= module_output_pin[0];
    end
    `CHK(acc, 1'b0)
    for (int c = 1; c < 4; c++) run_pwm(2'(c), 16'($urandom_range((256 << c) - 2, 1)));
    arm <= 1'b0;
    sel <= 3'h1;
    apb(1'b1, OFS_PULSE, 32'h00, '0, '0);
    apb(1'b1, ma(4'h1, MOD_MODE), 32'hCA, '0, '0);
    apb(1'b1, ma(4'h1, MOD_CMP_LO), 32'hF8, '0, '0);
    apb(1'b1, ma(4'h1, MOD_CMP_HI), 32'hFF, '0, '0);
    apb(1'b1, OFS_CTRL, 32'h00, '0, '0);
    apb(1'b1, OFS_CNT_LO, 32'hE0, '0, '0);
    apb(1'b1, OFS_CNT_HI, 32'hFF, '0, '0);
    apb(1'b0, OFS_CNT_HI, '0, 33'hFF, 33'hFF);
    apb(1'b1, OFS_CTRL, 32'h40, '0, '0);
    arm <= 1'b1;
    mq.push_back({16'h0008, 16'h0000});
    while (mq.size() > 0) @(posedge pclk);
    apb(1'b0, OFS_CTRL, '0, 33'h82, 33'h82);
    apb(1'b1, OFS_MODE, 32'h80, '0, '0);
    cpu_idle <= 1'b1;
    apb(1'b0, OFS_CNT_LO, '0, '0, '0);
    c0 = rdq;
    apb(1'b0, OFS_CNT_LO, '0, '0, '0);
    `CHK(rdq, c0)
    cpu_idle <= 1'b0;
    apb(1'b1, ma(4'h5, MOD_CMP_LO), 32'h01, '0, '0);
    apb(1'b1, ma(4'h5, MOD_CMP_HI), 32'h80, '0, '0);
    apb(1'b1, OFS_MODE, 32'h40, '0, '0);
    apb(1'b1, OFS_MODE, 32'hC0, '0, '0);
    apb(1'b0, OFS_MODE, '0, 33'hC0, 33'h40);
    n0 = rst_n;
    apb(1'b1, ma(4'h5, MOD_CMP_HI), 32'h00, '0, '0);
    t0 = cyc;
    k = 0;
    while (rst_n == n0 && k < 700) begin
      @(posedge pclk);
      k++;
    end
    `CHK(rst_n - n0 == 1 && rst_t - t0 >= 250 && rst_t - t0 <= 520, 1'b1)
    n0 = rst_n;
    apb(1'b1, OFS_CTRL, 32'h20, '0, '0);
    repeat (3) @(posedge pclk);
    `CHK(rst_n - n0 == 1, 1'b1)
    apb(1'b1, OFS_CTRL, '0, '0, '0);
    apb(1'b0, OFS_CTRL, '0, 33'h40, 33'h00);
    apb(1'b0, OFS_CNT_LO, '0, '0, '0);
    c0 = rdq;
    apb(1'b0, OFS_CNT_LO, '0, '0, '0);
    `CHK(rdq != c0, 1'b1)
    c0 = rdq;
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    apb(1'b0, OFS_CNT_LO, '0, '0, '0);
    `CHK(8'(rdq[7:0] - c0[7:0]) < 8'h14, 1'b1)
    apb(1'b1, OFS_MODE, 32'h20, '0, '0);
    apb(1'b1, OFS_MODE, '0, '0, '0);
    apb(1'b0, OFS_MODE, '0, 33'h60, 33'h60);
    results();
  end
endmodule
`undef CHK
`default_nettype wire

// File: test/pwm_pin_monitor.sv
// Purpose: Load on one module output pin that measures pulse high time and period
// Assumes: Pins sampled on pclk; one count tick per pclk
// Notes: Reports only whole pulses that begin after arm rises
`timescale 1ns/100ps
`default_nettype none
module pwm_pin_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed pins
  input wire logic [5:0] pins,
  input wire logic [2:0] sel,
  input wire logic arm,
  // Measurement
  output logic valid,
  output logic [15:0] high_len,
  output logic [15:0] period
);
  logic prev, seen_rise, seen_fall;
  logic [15:0] hc, pc;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {valid, prev, seen_rise, seen_fall} <= '0;
      {high_len, period, hc, pc} <= '0;
    end else begin
      valid <= 1'b0;
      prev <= pins[sel];
      if (!arm) begin
        {seen_rise, seen_fall, hc, pc} <= '0;
      end else begin
        pc <= pc + 16'h0001;
        if (pins[sel]) hc <= hc + 16'h0001;
        if (!prev && pins[sel]) seen_rise <= 1'b1;
        if (prev && !pins[sel]) begin
          valid <= seen_rise;
          high_len <= hc;
          period <= seen_fall ? pc + 16'h0001 : 16'h0000;
          seen_fall <= 1'b1;
          pc <= 16'h0000;
          hc <= 16'h0000;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/counter_array_pwm_watchdog.sv
// Purpose: Six-module counter array with PWM modes and module 5 watchdog, APB slave
// Assumes: count_tick and cpu_idle come from logic on pclk; ce freezes all state
// Notes: One wait state on every APB access
`timescale 1ns/100ps
`default_nettype none
module counter_array_pwm_watchdog (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [counter_array_pkg::ADDR_W-1:0] paddr,
  input wire logic [counter_array_pkg::DATA_W-1:0] pwdata,
  output logic [counter_array_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Counter time base
  input wire logic count_tick,
  input wire logic cpu_idle,
  // Module outputs and watchdog reset
  output logic [counter_array_pkg::NUM_MOD-1:0] module_output_pin,
  output logic watchdog_reset
);
  import counter_array_pkg::*;

  typedef struct packed {
    logic [15:0] cnt;
    logic run_sw;
    logic cf;
    logic [NUM_MOD-1:0] evt;
    logic idle_sus;
    logic wd_en;
    logic wd_lock;
    logic [CPS_W-1:0] clk_src;
    logic reload_access_select;
    logic cycle_overflow_flag;
    logic [CLS_W-1:0] cls;
    logic [NUM_MOD-1:0][7:0] mmode;
    logic [NUM_MOD-1:0][15:0] cmp;
    logic [NUM_MOD-1:0][15:0] rld;
    logic [NUM_MOD-1:0] pin;
    logic sys_rst;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } state_s;

  state_s st;
  state_s nx;

  logic acc;
  logic wr_fire;
  logic hit;
  logic mod_hit;
  logic [SUB_W-1:0] mod_row;
  logic [SUB_W-1:0] sub;
  logic [2:0] idx;
  logic [2:0] safe_idx;
  logic wd_on;
  logic wd5;
  logic running;
  logic tick;
  logic force_req;
  logic wr_cmp_lo;
  logic wr_cmp_hi;
  logic wd_expire;
  logic [7:0] wd_reload;
  logic [15:0] cnt_next;
  logic [DATA_W-1:0] rd;
  logic [NUM_MOD-1:0] ch_act;
  logic [NUM_MOD-1:0] ch_match;
  logic [NUM_MOD-1:0] ch_load;
  logic [NUM_MOD-1:0] ch_set;
  logic [NUM_MOD-1:0] ch_clr;
  logic [NUM_MOD-1:0][15:0] ch_load_val;

  // Address decode, read mux and time base
  always_comb begin
    acc = psel && penable;
    wr_fire = acc && st.pready && pwrite;
    mod_row = paddr[ADDR_W-1:SUB_W];
    sub = paddr[SUB_W-1:0];
    mod_hit = (mod_row >= MOD_ROW_BASE) && (mod_row < MOD_ROW_END) &&
              ((sub == MOD_MODE) || (sub == MOD_CMP_LO) || (sub == MOD_CMP_HI));
    idx = 3'(mod_row - MOD_ROW_BASE);
    safe_idx = mod_hit ? idx : 3'h0;
    wd_on = st.wd_en || st.wd_lock;
    wd5 = (safe_idx == WD_IDX) && wd_on;
    // Watchdog forces the counter on; idle suspend still applies
    running = (st.run_sw || wd_on) && !(st.idle_sus && cpu_idle);
    tick = count_tick && running;
    cnt_next = st.cnt + CNT_ONE;
    wr_cmp_lo = wr_fire && mod_hit && (sub == MOD_CMP_LO) && !st.reload_access_select;
    wr_cmp_hi = wr_fire && mod_hit && (sub == MOD_CMP_HI) && !st.reload_access_select;
    force_req = wr_fire && (paddr == OFS_CTRL) && pwdata[WD_MOD];
    rd = '0;
    hit = 1'b1;
    if (paddr == OFS_CTRL) begin
      rd[CTRL_CF] = st.cf;
      rd[CTRL_CR] = st.run_sw;
      rd[NUM_MOD-1:0] = st.evt;
    end else if (paddr == OFS_MODE) begin
      rd[MD_IDLE] = st.idle_sus;
      rd[MD_WATCHDOG_ENABLE_BIT] = st.wd_en;
      rd[MD_LOCK] = st.wd_lock;
      rd[MD_CPS_LO +: CPS_W] = st.clk_src;
    end else if (paddr == OFS_PULSE) begin
      rd[PC_RELOAD_ACCESS_SELECT] = st.reload_access_select;
      rd[PC_CYCLE_OVERFLOW_FLAG] = st.cycle_overflow_flag;
      rd[CLS_LSB +: CLS_W] = st.cls;
    end else if (paddr == OFS_CNT_LO) begin
      rd[BYTE_W-1:0] = lo_byte(st.cnt);
    end else if (paddr == OFS_CNT_HI) begin
      rd[BYTE_W-1:0] = hi_byte(st.cnt);
    end else if (mod_hit && (sub == MOD_MODE)) begin
      rd[BYTE_W-1:0] = st.mmode[safe_idx];
    end else if (mod_hit && (sub == MOD_CMP_LO)) begin
      rd[BYTE_W-1:0] = st.reload_access_select ? lo_byte(st.rld[safe_idx]) : lo_byte(st.cmp[safe_idx]);
    end else if (mod_hit) begin
      rd[BYTE_W-1:0] = st.reload_access_select ? hi_byte(st.rld[safe_idx]) : hi_byte(st.cmp[safe_idx]);
    end else begin
      hit = 1'b0;
    end
  end

  for (genvar g = 0; g < NUM_MOD; g++) begin : g_ch
    pwm_channel u_ch (
      .cycle_len(st.cls),
      .mode(st.mmode[g]),
      .cmp(st.cmp[g]),
      .rld(st.rld[g]),
      .cnt_next(cnt_next),
      .match(ch_match[g]),
      .load(ch_load[g]),
      .load_val(ch_load_val[g]),
      .pin_set(ch_set[g]),
      .pin_clr(ch_clr[g])
    );
  end

  watchdog_unit u_wd (
    .wd_on(wd_on),
    .tick(tick),
    .force_req(force_req),
    .cnt(st.cnt),
    .cnt_next(cnt_next),
    .update(hi_byte(st.cmp[WD_MOD])),
    .offset(lo_byte(st.cmp[WD_MOD])),
    .expire(wd_expire),
    .reload_val(wd_reload)
  );

  // Next state: bus answer, software writes, then hardware events
  always_comb begin
    nx = st;
    nx.pready = acc && !st.pready;
    nx.pslverr = acc && !st.pready && !hit;
    if (acc && !st.pready) begin
      nx.prdata = rd;
    end
    if (wr_fire && hit) begin
      if (paddr == OFS_CTRL) begin
        nx.cf = pwdata[CTRL_CF];
        nx.run_sw = pwdata[CTRL_CR];
        nx.evt = pwdata[NUM_MOD-1:0];
      end
      if (paddr == OFS_MODE) begin
        if (!wd_on) begin
          nx.idle_sus = pwdata[MD_IDLE];
          nx.clk_src = pwdata[MD_CPS_LO +: CPS_W];
        end
        nx.wd_lock = st.wd_lock || pwdata[MD_LOCK];
        nx.wd_en = nx.wd_lock || pwdata[MD_WATCHDOG_ENABLE_BIT];
      end
      if (paddr == OFS_PULSE) begin
        nx.reload_access_select = pwdata[PC_RELOAD_ACCESS_SELECT];
        nx.cycle_overflow_flag = pwdata[PC_CYCLE_OVERFLOW_FLAG];
        nx.cls = pwdata[CLS_LSB +: CLS_W];
      end
      if ((paddr == OFS_CNT_LO) && !wd_on) begin
        nx.cnt[LO_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
      end
      if ((paddr == OFS_CNT_HI) && !wd_on) begin
        nx.cnt[HI_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
      end
      if (mod_hit && (sub == MOD_MODE) && !wd5) begin
        nx.mmode[safe_idx] = pwdata[BYTE_W-1:0];
      end
      if (mod_hit && (sub == MOD_CMP_LO)) begin
        if (st.reload_access_select) begin
          nx.rld[safe_idx][LO_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
        end else begin
          nx.cmp[safe_idx][LO_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
          if (!wd5) begin
            nx.mmode[safe_idx][MM_ECOM] = 1'b0;
          end
        end
      end
      if (mod_hit && (sub == MOD_CMP_HI)) begin
        if (st.reload_access_select) begin
          nx.rld[safe_idx][HI_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
        end else if (wd5) begin
          nx.cmp[safe_idx][HI_LSB +: BYTE_W] = wd_reload;
        end else begin
          nx.cmp[safe_idx][HI_LSB +: BYTE_W] = pwdata[BYTE_W-1:0];
          nx.mmode[safe_idx][MM_ECOM] = 1'b1;
        end
      end
    end
    for (int i = 0; i < NUM_MOD; i++) begin
      // Module 5 leaves its compare duty to the watchdog while it is on
      ch_act[i] = !((i == WD_MOD) && wd_on);
    end
    if (tick) begin
      nx.cnt = cnt_next;
      if (cnt_next == CNT_ZERO) begin
        nx.cf = 1'b1;
      end
      if ((cnt_next & cycle_mask(st.cls)) == CNT_ZERO) begin
        nx.cycle_overflow_flag = 1'b1;
      end
      for (int i = 0; i < NUM_MOD; i++) begin
        if (ch_act[i]) begin
          if (ch_load[i]) begin
            nx.cmp[i] = ch_load_val[i];
          end
          if (ch_match[i] && st.mmode[i][MM_MAT]) begin
            nx.evt[i] = 1'b1;
          end
          if (ch_set[i]) begin
            nx.pin[i] = 1'b1;
          end else if (ch_clr[i]) begin
            nx.pin[i] = 1'b0;
          end
        end
      end
    end
    for (int i = 0; i < NUM_MOD; i++) begin
      if (!ch_act[i] || !st.mmode[i][MM_ECOM] || !st.mmode[i][MM_PWM]) begin
        nx.pin[i] = 1'b0;
      end
    end
    nx.sys_rst = wd_expire;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.wd_en <= WD_EN_RESET;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign module_output_pin = st.pin;
  assign watchdog_reset = st.sys_rst;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_wd_refresh;
    ce && wr_cmp_hi && (safe_idx == WD_IDX) && wd_on;
  endsequence

  sequence s_match0;
    ce && tick && ch_set[0];
  endsequence

  sequence s_wd_hit;
    ce && wd_on && tick && (lo_byte(cnt_next) == BYTE_ZERO) &&
    (hi_byte(st.cmp[WD_MOD]) == hi_byte(st.cnt));
  endsequence

  AST_ECOM_CLEAR: assert property (ce && wr_cmp_lo && !wd5 |=>
    !st.mmode[$past(safe_idx)][MM_ECOM]) else $error("compare low write kept enable");
  AST_ECOM_SET: assert property (ce && wr_cmp_hi && !wd5 |=>
    st.mmode[$past(safe_idx)][MM_ECOM]) else $error("compare high write missed enable");
  AST_WD_REFRESH: assert property (s_wd_refresh |=>
    hi_byte(st.cmp[WD_MOD]) == 8'($past(hi_byte(st.cnt)) + $past(lo_byte(st.cmp[WD_MOD]))))
    else $error("watchdog update byte wrong after refresh");
  AST_WD_EXPIRE: assert property (s_wd_hit |=> watchdog_reset)
    else $error("watchdog expiry gave no reset");
  AST_WD_LOCK: assert property (st.wd_lock |=> st.wd_lock && st.wd_en)
    else $error("locked watchdog was disabled");
  AST_CNT_FORCED: assert property (ce && wd_on && count_tick &&
    !(st.idle_sus && cpu_idle) |=> st.cnt == 16'($past(st.cnt) + CNT_ONE))
    else $error("counter did not run under watchdog");
  AST_CF_SET: assert property (ce && tick && (st.cnt == CNT_MAX) |=> st.cf)
    else $error("counter overflow flag not set");
  AST_CYCLE_OVERFLOW_FLAG_SET: assert property (ce && tick &&
    ((cnt_next & cycle_mask(st.cls)) == CNT_ZERO) |=> st.cycle_overflow_flag)
    else $error("cycle overflow flag not set");
  AST_PIN_RISE: assert property (s_match0 |=> st.pin[0] && module_output_pin[0])
    else $error("pin not set on match");
  AST_PIN_FALL: assert property (ce && tick && ch_clr[0] && !ch_set[0] |=>
    !module_output_pin[0]) else $error("pin not cleared on overflow");
  AST_NO_COMPARE: assert property (ce && !st.mmode[0][MM_ECOM] |=>
    !module_output_pin[0]) else $error("pin high with comparator off");
  AST_EVENT_SET: assert property (ce && tick && ch_match[0] && st.mmode[0][MM_MAT]
    |=> st.evt[0]) else $error("event flag missed on match");
  AST_RELOAD: assert property (ce && tick && ch_load[0] && !wr_fire |=>
    st.cmp[0] == $past(ch_load_val[0])) else $error("compare not reloaded at overflow");
  AST_APB_ONE_WAIT: assert property ($rose(psel && penable) && ce ##1 ce |-> pready)
    else $error("answer not in second access cycle");

endmodule
`default_nettype wire

// File: verilog/pwm_channel.sv
// Purpose: Compare logic of one counter array module
// Assumes: Evaluated against the counter value about to be loaded
// Notes: Purely combinational; the caller gates results with the count tick
`timescale 1ns/100ps
`default_nettype none
module pwm_channel (
  // Configuration and counter
  input wire logic [1:0] cycle_len,
  input wire logic [7:0] mode,
  input wire logic [15:0] cmp,
  input wire logic [15:0] rld,
  input wire logic [15:0] cnt_next,
  // Compare results
  output logic match,
  output logic load,
  output logic [15:0] load_val,
  output logic pin_set,
  output logic pin_clr
);
  import counter_array_pkg::*;

  logic narrow;
  logic wide;
  logic ovf;
  logic [15:0] mask;
  logic [15:0] eff;

  always_comb begin
    narrow = mode[MM_PWM] && !mode[MM_WIDE];
    wide = mode[MM_PWM] && mode[MM_WIDE];
    mask = narrow ? cycle_mask(cycle_len) : CNT_MAX;
    ovf = (cnt_next & mask) == CNT_ZERO;
    // 8-bit reload copies high byte to low byte, N-bit takes the reload register
    load_val = (cycle_len == CLS_8BIT) ? {hi_byte(cmp), hi_byte(cmp)} : rld;
    load = narrow && ovf;
    // A match right at the wrap compares with the freshly reloaded value
    eff = load ? load_val : cmp;
    match = mode[MM_ECOM] && ((cnt_next & mask) == (eff & mask));
    // Match wins over overflow so zero gives full duty
    pin_set = (narrow || wide) && match;
    pin_clr = (narrow || wide) && ovf;
  end

endmodule
`default_nettype wire

// File: verilog/watchdog_unit.sv
// Purpose: Expiry and refresh value of the module 5 watchdog
// Assumes: Counter low byte overflow is seen on the tick that wraps it to zero
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
module watchdog_unit (
  // Watchdog state
  input wire logic wd_on,
  input wire logic tick,
  input wire logic force_req,
  input wire logic [15:0] cnt,
  input wire logic [15:0] cnt_next,
  input wire logic [7:0] update,
  input wire logic [7:0] offset,
  // Results
  output logic expire,
  output logic [7:0] reload_val
);
  import counter_array_pkg::*;

  logic lo_ovf;

  always_comb begin
    // Refresh value: counter high byte plus the offset byte
    reload_val = 8'(hi_byte(cnt) + offset);
    lo_ovf = tick && (lo_byte(cnt_next) == BYTE_ZERO);
    // Reset on low-byte overflow while update byte equals counter high byte
    expire = wd_on && (force_req || (lo_ovf && (update == hi_byte(cnt))));
  end

endmodule
`default_nettype wire
